// ### logic/tmf_top.sv
// Overview of operation
// - negation inverts only the next event
// - negation only inside brackets, brackets automatic
// - interrupt fields active low, 1 means none
// - both interrupt fields 1 match no interrupt
// - negated no-interrupt clause fires on interrupt
// - block filter and command filter both exist
// - block filter defined once per run
// - block filter stores only matching cycles
// - fetch filter stores only fetch cycles
// - every stored sample keeps its fetch flag
// - store when block filter or command matches
// - filtering stores filtered only, delay ends run
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module tmf_top #(
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [tmf_pkg::DATA_W-1:0] sut_data,
    input wire logic [tmf_pkg::ADDR_W-1:0] sut_addr,
    input wire logic sut_irq_n,
    input wire logic sut_nmi_n,
    input wire logic sut_fetch,
    input wire logic sut_rw,
    input wire logic later_event,
    input wire logic qual_cmd,
    output logic trig_out,
    output logic irq
);
    import tmf_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("tmf_top: DEPTH must be a power of two, 2 to 256");
        end
    endgenerate

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SAMPLE_W-1:0] sync1;
        logic [SAMPLE_W-1:0] sync2;
        logic run;
        logic trig;
        logic done;
        logic wrap;
        logic qblk_en;
        logic negate;
        logic bracket;
        logic qcmd_use;
        logic [SAMPLE_W-1:0] tval;
        logic [SAMPLE_W-1:0] tcare;
        logic [SAMPLE_W-1:0] qval;
        logic [SAMPLE_W-1:0] qcare;
        logic [CNT_W-1:0] delay;
        logic [CNT_W-1:0] dcnt;
        logic [CNT_W-1:0] stored;
        logic [IDX_W-1:0] wptr;
        logic [IDX_W-1:0] rd_idx;
        logic [IDX_W-1:0] trig_loc;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_en;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [DEPTH-1:0][SAMPLE_W-1:0] mem;
    } tmf_state_t;

    tmf_state_t st_q;
    tmf_state_t st_d;

    logic [SAMPLE_W-1:0] sample;
    logic trig_hit;
    logic qual_hit;
    logic neg_eff;
    logic first_ev;
    logic clause;
    logic filt_used;
    logic store_ok;
    logic acq;
    logic store;
    logic trig_now;
    logic done_now;
    logic wrap_now;
    logic [CNT_W-1:0] dcnt_nx;
    logic [INT_W-1:0] ev;
    logic [INT_W-1:0] clr;
    logic addr_ok;

    assign sample = st_q.sync2;

    // ----------------------------------------------------------------
    // pattern matchers
    // ----------------------------------------------------------------
    tmf_matcher u_trig_match (
        .value(st_q.tval),
        .care(st_q.tcare),
        .sample(sample),
        .hit(trig_hit)
    );

    tmf_matcher u_qual_match (
        .value(st_q.qval),
        .care(st_q.qcare),
        .sample(sample),
        .hit(qual_hit)
    );

    // ----------------------------------------------------------------
    // event clause and storage decision
    // ----------------------------------------------------------------
    assign neg_eff = st_q.negate & st_q.bracket;
    assign first_ev = neg_eff ? ~trig_hit : trig_hit;
    assign clause = first_ev | later_event;
    assign filt_used = st_q.qblk_en | st_q.qcmd_use;
    assign store_ok = filt_used ?
        ((st_q.qblk_en & qual_hit) | qual_cmd) : 1'b1;
    assign acq = st_q.run & ~st_q.done;
    assign store = acq & store_ok;
    assign trig_now = acq & ~st_q.trig & clause;
    assign dcnt_nx = (st_q.trig & store) ? st_q.dcnt + 1'b1 : st_q.dcnt;
    assign done_now = acq & (trig_now | st_q.trig) &
        (dcnt_nx == st_q.delay);
    assign wrap_now = store & (st_q.wptr == IDX_W'(DEPTH - 1));
    assign ev = {wrap_now, done_now, trig_now};
    assign addr_ok = hsel & htrans[1] & hready;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        clr = '0;
        st_d.sync1 = {sut_rw, sut_fetch, sut_nmi_n, sut_irq_n,
            sut_addr, sut_data};
        st_d.sync2 = st_q.sync1;

        if (store) begin
            st_d.mem[st_q.wptr] = sample;
            st_d.wptr = st_q.wptr + 1'b1;
            if (st_q.stored != '1) begin
                st_d.stored = st_q.stored + 1'b1;
            end
        end
        if (wrap_now) begin
            st_d.wrap = 1'b1;
        end
        if (trig_now) begin
            st_d.trig = 1'b1;
            st_d.trig_loc = st_q.wptr;
        end
        st_d.dcnt = dcnt_nx;
        if (done_now) begin
            st_d.done = 1'b1;
            st_d.run = 1'b0;
        end

        // register write, data phase
        st_d.wr_pend = addr_ok & hwrite;
        st_d.wr_addr = haddr[7:0];
        if (st_q.wr_pend) begin
            if (st_q.wr_addr == OFS_CTRL) begin
                st_d.negate = hwdata[C_NEGATE];
                st_d.bracket = hwdata[C_BRACKET] | hwdata[C_NEGATE];
                st_d.qcmd_use = hwdata[C_QCMD_USE];
                if (!st_q.run) begin
                    st_d.qblk_en = hwdata[C_QBLK_EN];
                end
                if (hwdata[C_START]) begin
                    st_d.run = 1'b1;
                    st_d.trig = 1'b0;
                    st_d.done = 1'b0;
                    st_d.wrap = 1'b0;
                    st_d.wptr = '0;
                    st_d.dcnt = '0;
                    st_d.stored = '0;
                    st_d.trig_loc = '0;
                end
            end else if (st_q.wr_addr == OFS_TRIG_VAL) begin
                st_d.tval = hwdata[SAMPLE_W-1:0];
            end else if (st_q.wr_addr == OFS_TRIG_CARE) begin
                st_d.tcare = hwdata[SAMPLE_W-1:0];
            end else if (st_q.wr_addr == OFS_QUAL_VAL) begin
                if (!st_q.run) begin
                    st_d.qval = hwdata[SAMPLE_W-1:0];
                end
            end else if (st_q.wr_addr == OFS_QUAL_CARE) begin
                if (!st_q.run) begin
                    st_d.qcare = hwdata[SAMPLE_W-1:0];
                end
            end else if (st_q.wr_addr == OFS_DELAY) begin
                st_d.delay = hwdata[CNT_W-1:0];
            end else if (st_q.wr_addr == OFS_MEM_INDEX) begin
                st_d.rd_idx = hwdata[IDX_W-1:0];
            end else if (st_q.wr_addr == OFS_INT_CLR) begin
                clr = hwdata[INT_W-1:0];
            end else if (st_q.wr_addr == OFS_INT_EN) begin
                st_d.int_en = hwdata[INT_W-1:0];
            end
        end

        // sticky events, a set in the clearing cycle wins
        st_d.int_stat = (st_q.int_stat & ~clr) | ev;

        // register read, address phase
        st_d.rdata = '0;
        if (addr_ok && !hwrite) begin
            if (haddr[7:0] == OFS_CTRL) begin
                st_d.rdata[C_QBLK_EN] = st_q.qblk_en;
                st_d.rdata[C_NEGATE] = st_q.negate;
                st_d.rdata[C_BRACKET] = st_q.bracket;
                st_d.rdata[C_QCMD_USE] = st_q.qcmd_use;
            end else if (haddr[7:0] == OFS_STATUS) begin
                st_d.rdata[S_RUN] = st_q.run;
                st_d.rdata[S_TRIG] = st_q.trig;
                st_d.rdata[S_DONE] = st_q.done;
                st_d.rdata[S_WRAP] = st_q.wrap;
            end else if (haddr[7:0] == OFS_TRIG_VAL) begin
                st_d.rdata = 32'(st_q.tval);
            end else if (haddr[7:0] == OFS_TRIG_CARE) begin
                st_d.rdata = 32'(st_q.tcare);
            end else if (haddr[7:0] == OFS_QUAL_VAL) begin
                st_d.rdata = 32'(st_q.qval);
            end else if (haddr[7:0] == OFS_QUAL_CARE) begin
                st_d.rdata = 32'(st_q.qcare);
            end else if (haddr[7:0] == OFS_DELAY) begin
                st_d.rdata = 32'(st_q.delay);
            end else if (haddr[7:0] == OFS_COUNT) begin
                st_d.rdata = 32'(st_q.stored);
            end else if (haddr[7:0] == OFS_MEM_INDEX) begin
                st_d.rdata = 32'(st_q.rd_idx);
            end else if (haddr[7:0] == OFS_MEM_DATA) begin
                st_d.rdata = 32'(st_q.mem[st_q.rd_idx]);
                st_d.rd_idx = st_q.rd_idx + 1'b1;
            end else if (haddr[7:0] == OFS_INT_STAT) begin
                st_d.rdata = 32'(st_q.int_stat);
            end else if (haddr[7:0] == OFS_INT_EN) begin
                st_d.rdata = 32'(st_q.int_en);
            end else if (haddr[7:0] == OFS_TRIG_LOC) begin
                st_d.rdata = 32'(st_q.trig_loc);
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.delay <= RST_DELAY;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hreadyout = clk_en;
    assign hresp = 1'b0;
    assign hrdata = st_q.rdata;
    assign trig_out = st_q.trig;
    assign irq = |(st_q.int_stat & st_q.int_en);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_armed;
        acq && !st_q.trig && clk_en;
    endsequence

    sequence s_fires;
        ##1 st_q.trig ##1 (st_q.trig || !clk_en || st_q.run);
    endsequence

    a_neg_first: assert property (
        (s_armed and (neg_eff && trig_hit && !later_event)) |=> !st_q.trig)
        else $error("negated matched event fired the trigger");

    a_neg_bracket: assert property (
        st_q.negate |-> st_q.bracket)
        else $error("negation held without brackets");

    a_irq_low: assert property (
        (st_q.tcare[F_IRQ_N] && st_q.tval[F_IRQ_N] && !sample[F_IRQ_N])
        |-> !trig_hit)
        else $error("irq field 1 matched an asserted interrupt");

    a_no_int: assert property (
        (trig_hit && st_q.tcare[F_IRQ_N] && st_q.tval[F_IRQ_N] &&
        st_q.tcare[F_NMI_N] && st_q.tval[F_NMI_N])
        |-> (sample[F_IRQ_N] && sample[F_NMI_N]))
        else $error("no-interrupt matcher true during interrupt");

    a_trig_fire: assert property (
        (s_armed and (neg_eff && !trig_hit)) |-> s_fires)
        else $error("trigger missed a true clause");

    a_block_once: assert property (
        (st_q.run && $past(st_q.run)) |-> ($stable(st_q.qcare) &&
        $stable(st_q.qval) && $stable(st_q.qblk_en)))
        else $error("block filter changed during a run");

    a_store_filt: assert property (
        (store && filt_used && !qual_cmd) |-> (st_q.qblk_en && qual_hit))
        else $error("cycle stored without a filter match");

    a_fetch_only: assert property (
        (store && st_q.qblk_en && !qual_cmd && st_q.qcare[F_FETCH] &&
        st_q.qval[F_FETCH]) |-> sample[F_FETCH])
        else $error("non-fetch cycle stored by fetch filter");

    a_fetch_kept: assert property (
        (store && clk_en) |=>
        (st_q.mem[$past(st_q.wptr)][F_FETCH] == $past(sample[F_FETCH])))
        else $error("stored sample lost its fetch flag");

    a_cmd_or: assert property (
        (acq && qual_cmd && clk_en) |=> (st_q.stored != $past(st_q.stored)
        || st_q.stored == '1 || !st_q.run && !st_q.done))
        else $error("command filter did not store");

    a_done_delay: assert property (
        $rose(st_q.done) |-> (st_q.dcnt == st_q.delay && st_q.trig))
        else $error("run ended before the delay count");

endmodule

// ### logic/tmf_pkg.sv
package tmf_pkg;

    // ----------------------------------------------------------------
    // sample layout
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int SAMPLE_W = 28;
    localparam int F_DATA_LSB = 0;
    localparam int F_ADDR_LSB = 8;
    localparam int F_IRQ_N = 24;
    localparam int F_NMI_N = 25;
    localparam int F_FETCH = 26;
    localparam int F_RW = 27;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_TRIG_VAL = 8'h08;
    localparam logic [7:0] OFS_TRIG_CARE = 8'h0c;
    localparam logic [7:0] OFS_QUAL_VAL = 8'h10;
    localparam logic [7:0] OFS_QUAL_CARE = 8'h14;
    localparam logic [7:0] OFS_DELAY = 8'h18;
    localparam logic [7:0] OFS_COUNT = 8'h1c;
    localparam logic [7:0] OFS_MEM_INDEX = 8'h20;
    localparam logic [7:0] OFS_MEM_DATA = 8'h24;
    localparam logic [7:0] OFS_INT_STAT = 8'h28;
    localparam logic [7:0] OFS_INT_CLR = 8'h2c;
    localparam logic [7:0] OFS_INT_EN = 8'h30;
    localparam logic [7:0] OFS_TRIG_LOC = 8'h34;

    // ----------------------------------------------------------------
    // control, status and interrupt bit positions
    // ----------------------------------------------------------------
    localparam int C_START = 0;
    localparam int C_QBLK_EN = 1;
    localparam int C_NEGATE = 2;
    localparam int C_BRACKET = 3;
    localparam int C_QCMD_USE = 4;
    localparam int S_RUN = 0;
    localparam int S_TRIG = 1;
    localparam int S_DONE = 2;
    localparam int S_WRAP = 3;
    localparam int INT_W = 3;
    localparam int I_TRIG = 0;
    localparam int I_DONE = 1;
    localparam int I_WRAP = 2;

    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] RST_DELAY = 16'h0008;

endpackage

// ### logic/tmf_matcher.sv
`timescale 1ns/1ps
module tmf_matcher (
    input wire logic [tmf_pkg::SAMPLE_W-1:0] value,
    input wire logic [tmf_pkg::SAMPLE_W-1:0] care,
    input wire logic [tmf_pkg::SAMPLE_W-1:0] sample,
    output logic hit
);
    import tmf_pkg::*;

    logic [SAMPLE_W-1:0] bit_ok;

    // ----------------------------------------------------------------
    // per-field compare, interrupt fields taken at pin level (low true)
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < SAMPLE_W; i++) begin : g_bit
            assign bit_ok[i] = ~care[i] | (value[i] == sample[i]);
        end
    endgenerate

    assign hit = &bit_ok;

endmodule

// ### verif/tmf_sut_model.sv
`timescale 1ns/1ps
module tmf_sut_model (
    input wire logic core_clk,
    input wire logic irq_req,
    input wire logic nmi_req,
    output logic [7:0] sut_data = 8'h00,
    output logic [15:0] sut_addr = 16'h0000,
    output logic sut_irq_n = 1'b1,
    output logic sut_nmi_n = 1'b1,
    output logic sut_fetch = 1'b0,
    output logic sut_rw = 1'b1
);
    logic [7:0] cyc_q = 8'h00;

    // ----------------------------------------------------------------
    // processor bus cycles, a fetch on every other cycle
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc_q <= cyc_q + 8'h01;
        sut_addr <= 16'hf82c + {12'h000, cyc_q[3:0]};
        sut_data <= cyc_q ^ 8'h5a;
        sut_fetch <= cyc_q[0];
        sut_rw <= ~cyc_q[1];
        sut_irq_n <= ~irq_req;
        sut_nmi_n <= ~nmi_req;
    end
endmodule

// ### verif/tmf_top_test.sv
`timescale 1ns/1ps
module tmf_top_test;
    import tmf_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic trig_out;
    logic irq;
    logic [31:0] hrdata;
    logic [DATA_W-1:0] sut_data;
    logic [ADDR_W-1:0] sut_addr;
    logic sut_irq_n;
    logic sut_nmi_n;
    logic sut_fetch;
    logic sut_rw;
    logic later_event = 1'b0;
    logic qual_cmd = 1'b0;
    logic irq_req = 1'b0;
    logic nmi_req = 1'b0;
    logic [31:0] rd;
    int n_errors = 0;
    int n_tests = 0;
    int n;
    int nz;

    assign hready = hreadyout;
    always #4 core_clk = ~core_clk;

    tmf_top #(.DEPTH(16)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sut_data(sut_data), .sut_addr(sut_addr), .sut_irq_n(sut_irq_n),
        .sut_nmi_n(sut_nmi_n), .sut_fetch(sut_fetch), .sut_rw(sut_rw),
        .later_event(later_event), .qual_cmd(qual_cmd),
        .trig_out(trig_out), .irq(irq));

    tmf_sut_model u_sut (.core_clk(core_clk), .irq_req(irq_req),
        .nmi_req(nmi_req), .sut_data(sut_data), .sut_addr(sut_addr),
        .sut_irq_n(sut_irq_n), .sut_nmi_n(sut_nmi_n),
        .sut_fetch(sut_fetch), .sut_rw(sut_rw));

    // ----------------------------------------------------------------
    // bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        @(posedge core_clk);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a);
        check(rd, exp);
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge core_clk);
    endtask

    task automatic wait_done();
        int i;
        i = 0;
        rd_reg(OFS_STATUS);
        while (rd[S_DONE] !== 1'b1 && i < 40) begin
            rd_reg(OFS_STATUS);
            i++;
        end
        check(rd[S_DONE], 1'b1);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_errors++;
        conclude();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk_reg(OFS_DELAY, 32'h0000_0008);
        chk_reg(OFS_STATUS, 32'h0);
        check(hresp, 1'b0);
        wr(8'h3c, 32'hffff_ffff);
        chk_reg(8'h3c, 32'h0);
        $display("reset test done");
        wr(OFS_TRIG_VAL, 32'h0300_0000);
        wr(OFS_TRIG_CARE, 32'h0300_0000);
        wr(OFS_CTRL, 32'h0000_0004);
        chk_reg(OFS_CTRL, 32'h0000_000c);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_CTRL, 32'h0000_000d);
            idle(20);
            check(trig_out, 1'b0);
            @(posedge core_clk);
            irq_req <= (k == 0);
            nmi_req <= (k == 1);
            idle(6);
            check(trig_out, 1'b1);
            @(posedge core_clk);
            irq_req <= 1'b0;
            nmi_req <= 1'b0;
        end
        wr(OFS_CTRL, 32'h0000_000d);
        idle(20);
        @(posedge core_clk);
        later_event <= 1'b1;
        idle(6);
        check(trig_out, 1'b1);
        @(posedge core_clk);
        later_event <= 1'b0;
        irq_req <= 1'b1;
        wr(OFS_CTRL, 32'h0000_0001);
        idle(20);
        check(trig_out, 1'b0);
        @(posedge core_clk);
        irq_req <= 1'b0;
        idle(6);
        check(trig_out, 1'b1);
        wait_done();
        $display("negation test done");
        wr(OFS_TRIG_CARE, 32'h0);
        wr(OFS_DELAY, 32'h0000_0006);
        wr(OFS_QUAL_VAL, 32'h0400_0000);
        wr(OFS_QUAL_CARE, 32'h0400_0000);
        wr(OFS_CTRL, 32'h0000_0003);
        wait_done();
        check(rd[S_DONE], 1'b1);
        rd_reg(OFS_COUNT);
        n = rd;
        check(n == 6 || n == 7, 1'b1);
        wr(OFS_MEM_INDEX, 32'h0);
        for (int i = 0; i < n; i++) begin
            rd_reg(OFS_MEM_DATA);
            check(rd[F_FETCH], 1'b1);
        end
        $display("block filter test done");
        wr(OFS_CTRL, 32'h0000_0011);
        idle(30);
        chk_reg(OFS_STATUS, 32'h0000_0003);
        chk_reg(OFS_COUNT, 32'h0);
        wr(OFS_QUAL_VAL, 32'h0);
        chk_reg(OFS_QUAL_VAL, 32'h0400_0000);
        @(posedge core_clk);
        qual_cmd <= 1'b1;
        wait_done();
        check(rd[S_DONE], 1'b1);
        wr(OFS_CTRL, 32'h0000_0013);
        wait_done();
        rd_reg(OFS_COUNT);
        n = rd;
        nz = 0;
        wr(OFS_MEM_INDEX, 32'h0);
        for (int i = 0; i < n; i++) begin
            rd_reg(OFS_MEM_DATA);
            nz += (rd[F_FETCH] == 1'b0);
        end
        check(nz != 0, 1'b1);
        @(posedge core_clk);
        qual_cmd <= 1'b0;
        $display("command filter test done");
        wr(OFS_INT_EN, 32'h0);
        wr(OFS_INT_CLR, 32'h0000_0007);
        chk_reg(OFS_INT_STAT, 32'h0);
        wr(OFS_CTRL, 32'h0000_0001);
        wait_done();
        chk_reg(OFS_INT_STAT, 32'h0000_0003);
        idle(1);
        check(irq, 1'b0);
        wr(OFS_INT_EN, 32'h0000_0001);
        idle(1);
        check(irq, 1'b1);
        wr(OFS_INT_CLR, 32'h0000_0001);
        idle(1);
        check(irq, 1'b0);
        chk_reg(OFS_INT_STAT, 32'h0000_0002);
        chk_reg(OFS_INT_CLR, 32'h0);
        wr(OFS_INT_EN, 32'h0000_0002);
        idle(1);
        check(irq, 1'b1);
        $display("interrupt test done");
        conclude();
    end
endmodule
